/* File: src/cbm_pkg.sv */
package cbm_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STAT = 8'h04;
    localparam logic [7:0] ADDR_BSEL = 8'h08;
    localparam logic [7:0] ADDR_ENH = 8'h0c;
    localparam logic [7:0] ADDR_FC0 = 8'h10;
    localparam logic [7:0] ADDR_INT_STAT = 8'h28;
    localparam logic [7:0] ADDR_INT_MASK = 8'h2c;
    localparam int NUM_BUF = 6;
    localparam int NUM_INT = 7;
    // field positions
    localparam int REQ_LSB = 5;
    localparam int ABORT_BIT = 4;
    localparam int WIN_LSB = 1;
    localparam int CURRENT_OPERATING_MODE_LSB = 5;
    localparam int INTERRUPT_CAUSE_CODE_LSB = 1;
    localparam int RTR_BIT = 6;
    localparam int BSEL_LSB = 2;
    localparam int WAKE_BIT = 6;
    // operating mode codes
    localparam logic [2:0] MODE_NORMAL = 3'h0;
    localparam logic [2:0] MODE_CONFIG = 3'h4;
    // enhanced mode codes
    localparam logic [1:0] ENH_LEGACY = 2'h0;
    localparam logic [1:0] ENH_MAX = 2'h2;
    // reset values, length clamp and no-cause code
    localparam logic [2:0] REQ_RST = 3'h4;
    localparam logic [2:0] WIN_RST = 3'h0;
    localparam logic [5:0] BSEL_RST = 6'h00;
    localparam logic [1:0] ENH_RST = 2'h0;
    localparam logic [6:0] INT_RST = 7'h00;
    localparam logic [3:0] DLC_MAX = 4'h8;
    localparam logic [2:0] INTERRUPT_CAUSE_CODE_NONE = 3'h0;
endpackage

/* File: src/cbm_sync3.sv */
`timescale 1ns/10ps
module cbm_sync3 (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // level in and out
    input wire logic din,
    output logic dout
);
    logic s1_ff, s2_ff, s3_ff, q_ff;
    logic nxt_q;

    // a change counts only once the second and third stages agree
    always_comb
    begin
        nxt_q = q_ff;
        if (s2_ff == s3_ff)
        begin
            nxt_q = s3_ff;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s1_ff <= 1'b0;
            s2_ff <= 1'b0;
            s3_ff <= 1'b0;
            q_ff <= 1'b0;
        end
        else
        begin
            s1_ff <= din;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            q_ff <= nxt_q;
        end
    end

    assign dout = q_ff;
endmodule // cbm_sync3

/* File: src/cbm_ctrl.sv */
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
// Notes on behaviour
// - a request for configuration mode is held off until the bus is seen idle.
// - requests for operating modes zero to three take effect at once; codes five to seven also wait for idle and enter configuration.
// - the status register shows the operating mode actually in force.
// - the cause code encodes none, error, tx2, tx1, tx0, rx1, rx0, wake-up as zero to seven.
// - the wake-up flag stays set until software clears it.
// - length codes zero to eight give the byte count, nine to fifteen are reserved.
// - the frame control layout of each of six buffers applies only while its transmit enable is set.
// - buffer select bits seven to two make buffers five to zero transmit (one) or receive (zero).
// - buffer length and select registers exist only in enhanced modes one and two.
// - the two low bits of the buffer select register read as zero.
// - the abort-all request clears itself once no transmission is pending.
module cbm_ctrl (
    // apb slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // can core side
    input wire logic bus_idle_pin,
    input wire logic err_evt,
    input wire logic [2:0] txb_evt,
    input wire logic [1:0] rxb_evt,
    input wire logic wake_evt,
    input wire logic [2:0] tx_pending,
    // control out
    output logic [2:0] current_operating_mode,
    output logic abort_all_tx,
    output logic [5:0] buffer_tx_enable,
    output logic [5:0] tx_remote_request,
    output logic [23:0] buffer_dlc,
    output logic [23:0] buffer_len,
    output logic irq
);
    logic bus_idle_s;
    logic acc, wr, rd;
    logic [2:0] req_ff, nxt_req, cur_ff, nxt_cur, win_ff, nxt_win;
    logic abort_ff, nxt_abort;
    logic [1:0] enh_ff, nxt_enh;
    logic [5:0] sel_ff, nxt_sel, rtr_ff, nxt_rtr;
    logic [23:0] dlc_ff, nxt_dlc, len_ff, nxt_len;
    logic [6:0] pend_ff, nxt_pend, mask_ff, nxt_mask, evt;
    logic [2:0] interrupt_cause_code;
    logic irq_ff, nxt_irq;
    logic pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;
    logic [31:0] prdata_ff, nxt_prdata;

    cbm_sync3 u_idle_sync (
        .pclk(pclk),
        .presetn(presetn),
        .din(bus_idle_pin),
        .dout(bus_idle_s)
    );

    // one wait state so that read data comes from a flop
    assign acc = psel && penable && pready_ff;
    assign wr = acc && pwrite;
    assign rd = acc && !pwrite;
    assign evt = {wake_evt, rxb_evt[0], rxb_evt[1], txb_evt[0], txb_evt[1], txb_evt[2], err_evt};

    // lowest code wins when several causes are pending
    always_comb
    begin
        interrupt_cause_code = cbm_pkg::INTERRUPT_CAUSE_CODE_NONE;
        for (int i = cbm_pkg::NUM_INT - 1; i >= 0; i--)
        begin
            if (pend_ff[i] && mask_ff[i])
            begin
                interrupt_cause_code = 3'(i + 1);
            end
        end
    end

    // control, mode and interrupt state
    always_comb
    begin
        nxt_req = req_ff;
        nxt_win = win_ff;
        nxt_abort = abort_ff;
        nxt_enh = enh_ff;
        nxt_mask = mask_ff;
        if (abort_ff && tx_pending == 3'h0)
        begin
            nxt_abort = 1'b0;
        end
        if (wr && paddr == cbm_pkg::ADDR_CTRL)
        begin
            nxt_req = pwdata[cbm_pkg::REQ_LSB +: 3];
            nxt_win = pwdata[cbm_pkg::WIN_LSB +: 3];
            if (pwdata[cbm_pkg::ABORT_BIT])
            begin
                nxt_abort = 1'b1;
            end
        end
        if (wr && paddr == cbm_pkg::ADDR_ENH && pwdata[1:0] <= cbm_pkg::ENH_MAX)
        begin
            nxt_enh = pwdata[1:0];
        end
        if (wr && paddr == cbm_pkg::ADDR_INT_MASK)
        begin
            nxt_mask = pwdata[6:0];
        end
        // configuration waits for an idle bus so no frame is cut short
        nxt_cur = cur_ff;
        if (req_ff[2])
        begin
            if (bus_idle_s)
            begin
                nxt_cur = cbm_pkg::MODE_CONFIG;
            end
        end
        else
        begin
            nxt_cur = req_ff;
        end
        // set wins over a write-one clear
        nxt_pend = pend_ff;
        if (wr && paddr == cbm_pkg::ADDR_INT_STAT)
        begin
            nxt_pend = pend_ff & ~pwdata[6:0];
        end
        nxt_pend = nxt_pend | evt;
        nxt_irq = |(nxt_pend & nxt_mask);
    end

    // buffer direction and frame control
    always_comb
    begin
        nxt_sel = sel_ff;
        nxt_rtr = rtr_ff;
        nxt_dlc = dlc_ff;
        if (wr && paddr == cbm_pkg::ADDR_BSEL && enh_ff != cbm_pkg::ENH_LEGACY)
        begin
            nxt_sel = pwdata[cbm_pkg::BSEL_LSB +: 6];
        end
        if (nxt_enh == cbm_pkg::ENH_LEGACY)
        begin
            nxt_sel = cbm_pkg::BSEL_RST;
        end
        for (int n = 0; n < cbm_pkg::NUM_BUF; n++)
        begin
            if (wr && paddr == cbm_pkg::ADDR_FC0 + 8'(4 * n) && sel_ff[n] && enh_ff != cbm_pkg::ENH_LEGACY)
            begin
                nxt_rtr[n] = pwdata[cbm_pkg::RTR_BIT];
                nxt_dlc[4 * n +: 4] = pwdata[3:0];
            end
        end
    end

    // reserved length codes clamp to eight bytes
    genvar g;
    generate
        for (g = 0; g < cbm_pkg::NUM_BUF; g++)
        begin : g_len
            assign nxt_len[4 * g +: 4] = !nxt_sel[g] ? 4'h0 :
                (nxt_dlc[4 * g +: 4] > cbm_pkg::DLC_MAX) ? cbm_pkg::DLC_MAX : nxt_dlc[4 * g +: 4];
        end
    endgenerate

    // apb answer
    always_comb
    begin
        nxt_pready = psel && penable && !pready_ff;
        nxt_pslverr = 1'b0;
        nxt_prdata = 32'h0000_0000;
        if (psel && penable && !pready_ff)
        begin
            unique case (paddr)
                cbm_pkg::ADDR_CTRL:
                begin
                    nxt_prdata[cbm_pkg::REQ_LSB +: 3] = req_ff;
                    nxt_prdata[cbm_pkg::ABORT_BIT] = abort_ff;
                    nxt_prdata[cbm_pkg::WIN_LSB +: 3] = win_ff;
                end
                cbm_pkg::ADDR_STAT:
                begin
                    nxt_prdata[cbm_pkg::CURRENT_OPERATING_MODE_LSB +: 3] = cur_ff;
                    nxt_prdata[cbm_pkg::INTERRUPT_CAUSE_CODE_LSB +: 3] = interrupt_cause_code;
                end
                cbm_pkg::ADDR_BSEL:
                begin
                    nxt_prdata[cbm_pkg::BSEL_LSB +: 6] = sel_ff;
                end
                cbm_pkg::ADDR_ENH:
                begin
                    nxt_prdata[1:0] = enh_ff;
                end
                cbm_pkg::ADDR_INT_STAT:
                begin
                    nxt_prdata[6:0] = pend_ff;
                end
                cbm_pkg::ADDR_INT_MASK:
                begin
                    nxt_prdata[6:0] = mask_ff;
                end
                default:
                begin
                    nxt_pslverr = 1'b1;
                    for (int n = 0; n < cbm_pkg::NUM_BUF; n++)
                    begin
                        if (paddr == cbm_pkg::ADDR_FC0 + 8'(4 * n))
                        begin
                            nxt_pslverr = 1'b0;
                            // receive-mode layout is not held here, so it reads as zero
                            if (sel_ff[n])
                            begin
                                nxt_prdata[cbm_pkg::RTR_BIT] = rtr_ff[n];
                                nxt_prdata[3:0] = dlc_ff[4 * n +: 4];
                            end
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            req_ff <= cbm_pkg::REQ_RST;
            cur_ff <= cbm_pkg::MODE_CONFIG;
            win_ff <= cbm_pkg::WIN_RST;
            abort_ff <= 1'b0;
            enh_ff <= cbm_pkg::ENH_RST;
            sel_ff <= cbm_pkg::BSEL_RST;
            rtr_ff <= 6'h00;
            dlc_ff <= 24'h00_0000;
            len_ff <= 24'h00_0000;
            pend_ff <= cbm_pkg::INT_RST;
            mask_ff <= cbm_pkg::INT_RST;
            irq_ff <= 1'b0;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end
        else
        begin
            req_ff <= nxt_req;
            cur_ff <= nxt_cur;
            win_ff <= nxt_win;
            abort_ff <= nxt_abort;
            enh_ff <= nxt_enh;
            sel_ff <= nxt_sel;
            rtr_ff <= nxt_rtr;
            dlc_ff <= nxt_dlc;
            len_ff <= nxt_len;
            pend_ff <= nxt_pend;
            mask_ff <= nxt_mask;
            irq_ff <= nxt_irq;
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            prdata_ff <= nxt_prdata;
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign current_operating_mode = cur_ff;
    assign abort_all_tx = abort_ff;
    assign buffer_tx_enable = sel_ff;
    assign tx_remote_request = rtr_ff;
    assign buffer_dlc = dlc_ff;
    assign buffer_len = len_ff;
    assign irq = irq_ff;

    property p_cfg_wait;
        @(posedge pclk) disable iff (!presetn)
        (req_ff[2] && !bus_idle_s && cur_ff != cbm_pkg::MODE_CONFIG) |=> cur_ff != cbm_pkg::MODE_CONFIG;
    endproperty
    a_cfg_wait: assert property (p_cfg_wait) else $error("config entered on busy bus");
    property p_cfg_enter;
        @(posedge pclk) disable iff (!presetn)
        (req_ff[2] && bus_idle_s) |=> cur_ff == cbm_pkg::MODE_CONFIG;
    endproperty
    a_cfg_enter: assert property (p_cfg_enter) else $error("config not entered on idle bus");
    property p_imm_mode;
        @(posedge pclk) disable iff (!presetn)
        wr && paddr == cbm_pkg::ADDR_CTRL && !pwdata[7] |=> ##1 cur_ff == $past(pwdata[7:5], 2);
    endproperty
    a_imm_mode: assert property (p_imm_mode) else $error("mode not taken at once");
    property p_stat_mode;
        @(posedge pclk) disable iff (!presetn)
        rd && paddr == cbm_pkg::ADDR_STAT |-> prdata[7:5] == $past(cur_ff);
    endproperty
    a_stat_mode: assert property (p_stat_mode) else $error("status mode mismatch");
    property p_interrupt_cause_code_err;
        @(posedge pclk) disable iff (!presetn)
        pend_ff[0] && mask_ff[0] |-> interrupt_cause_code == 3'h1;
    endproperty
    a_interrupt_cause_code_err: assert property (p_interrupt_cause_code_err) else $error("error cause code wrong");
    property p_wake_hold;
        @(posedge pclk) disable iff (!presetn)
        pend_ff[cbm_pkg::WAKE_BIT] && !(wr && paddr == cbm_pkg::ADDR_INT_STAT) |=> pend_ff[cbm_pkg::WAKE_BIT];
    endproperty
    a_wake_hold: assert property (p_wake_hold) else $error("wake flag dropped");
    property p_rtr_wr;
        @(posedge pclk) disable iff (!presetn)
        wr && paddr == cbm_pkg::ADDR_FC0 && sel_ff[0] && enh_ff != 2'h0 |=> tx_remote_request[0] == $past(pwdata[6]);
    endproperty
    a_rtr_wr: assert property (p_rtr_wr) else $error("rtr not stored");
    property p_len_clamp;
        @(posedge pclk) disable iff (!presetn)
        sel_ff[0] && dlc_ff[3:0] > 4'h8 |-> len_ff[3:0] == 4'h8;
    endproperty
    a_len_clamp: assert property (p_len_clamp) else $error("reserved length not clamped");
    property p_bsel_low;
        @(posedge pclk) disable iff (!presetn)
        rd && paddr == cbm_pkg::ADDR_BSEL |-> prdata[1:0] == 2'h0;
    endproperty
    a_bsel_low: assert property (p_bsel_low) else $error("select low bits not zero");
    property p_legacy;
        @(posedge pclk) disable iff (!presetn)
        enh_ff == cbm_pkg::ENH_LEGACY |-> sel_ff == 6'h00;
    endproperty
    a_legacy: assert property (p_legacy) else $error("select active in legacy mode");
    property p_abort_clr;
        @(posedge pclk) disable iff (!presetn)
        abort_ff && tx_pending == 3'h0 && !wr |=> !abort_ff;
    endproperty
    a_abort_clr: assert property (p_abort_clr) else $error("abort did not clear");

    c_cfg: cover property (@(posedge pclk) disable iff (!presetn) req_ff[2] && !bus_idle_s ##1 bus_idle_s);
    c_wake: cover property (@(posedge pclk) disable iff (!presetn) wake_evt ##2 irq);
    c_abort: cover property (@(posedge pclk) disable iff (!presetn) $fell(abort_ff));
endmodule // cbm_ctrl

/* File: tb/cbm_bus_node.sv */
`timescale 1ns/10ps
module cbm_bus_node (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // bench control
    input wire logic frame_start,
    input wire logic [6:0] evt_req,
    input wire logic [2:0] pend_set,
    // controller side
    input wire logic abort_all_tx,
    output logic bus_idle_pin,
    output logic err_evt,
    output logic [2:0] txb_evt,
    output logic [1:0] rxb_evt,
    output logic wake_evt,
    output logic [2:0] tx_pending
);
    int busy_ff;
    logic [6:0] evt_ff;
    logic [2:0] pend_ff;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            busy_ff <= 0;
            evt_ff <= 7'h00;
            pend_ff <= 3'h0;
        end
        else
        begin
            // one frame holds the bus for a fixed run of cycles
            busy_ff <= frame_start ? 40 : (busy_ff > 0 ? busy_ff - 1 : 0);
            evt_ff <= evt_req;
            // queued frames are dropped a cycle after the abort shows
            pend_ff <= abort_all_tx ? 3'h0 : (pend_ff | pend_set);
        end
    end
    assign bus_idle_pin = (busy_ff == 0);
    assign {wake_evt, rxb_evt[0], rxb_evt[1], txb_evt[0], txb_evt[1], txb_evt[2], err_evt} = evt_ff;
    assign tx_pending = pend_ff;
endmodule // cbm_bus_node

/* File: tb/tb_can_buffer_mode_control.sv */
`timescale 1ns/10ps
module tb_can_buffer_mode_control;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic frame_start = 1'b0;
    logic [6:0] evt_req = 7'h00;
    logic [2:0] pend_set = 3'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, er, bus_idle_pin, err_evt, wake_evt, abort_all_tx, irq;
    logic [2:0] txb_evt, tx_pending, current_operating_mode;
    logic [1:0] rxb_evt;
    logic [5:0] buffer_tx_enable, tx_remote_request;
    logic [23:0] buffer_dlc, buffer_len;
    int m_req = 4, m_win = 0, m_bsel = 0, m_enh = 0, m_stat = 0, m_mask = 0, m_mode = 4;
    int m_fc[6] = '{default: 0};
    int fail_count = 0, cmp_count = 0, cyc = 0, n;
    cbm_ctrl cbm_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .bus_idle_pin(bus_idle_pin), .err_evt(err_evt), .txb_evt(txb_evt), .rxb_evt(rxb_evt),
        .wake_evt(wake_evt), .tx_pending(tx_pending), .current_operating_mode(current_operating_mode),
        .abort_all_tx(abort_all_tx), .buffer_tx_enable(buffer_tx_enable), .tx_remote_request(tx_remote_request),
        .buffer_dlc(buffer_dlc), .buffer_len(buffer_len), .irq(irq));
    cbm_bus_node cbm_bus_node_i (.pclk(pclk), .presetn(presetn), .frame_start(frame_start), .evt_req(evt_req),
        .pend_set(pend_set), .abort_all_tx(abort_all_tx), .bus_idle_pin(bus_idle_pin), .err_evt(err_evt),
        .txb_evt(txb_evt), .rxb_evt(rxb_evt), .wake_evt(wake_evt), .tx_pending(tx_pending));
    always #2 pclk = ~pclk;
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fail_count++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    function automatic int m_read(input int a);
        int ic;
        ic = 0;
        for (int i = 6; i >= 0; i--)
            if (m_stat[i] & m_mask[i]) ic = i + 1;
        if (a >= 'h10 && a <= 'h24) return m_bsel[(a - 16) / 4] ? m_fc[(a - 16) / 4] : 0;
        case (a)
            'h00: return (m_req << 5) | (m_win << 1);
            'h04: return (m_mode << 5) | (ic << 1);
            'h08: return m_bsel << 2;
            'h0c: return m_enh;
            'h28: return m_stat;
            'h2c: return m_mask;
            default: return 0;
        endcase
    endfunction
    function automatic void m_write(input int a, input int d);
        if (a == 'h00)
        begin
            m_req = (d >> 5) & 7;
            m_win = (d >> 1) & 7;
            if (m_req < 4) m_mode = m_req;
        end
        if (a == 'h08 && m_enh != 0) m_bsel = (d >> 2) & 63;
        if (a == 'h0c && (d & 3) != 3) m_enh = d & 3;
        if (m_enh == 0) m_bsel = 0;
        if (a >= 'h10 && a <= 'h24 && m_enh != 0 && m_bsel[(a - 16) / 4]) m_fc[(a - 16) / 4] = d & 'h4f;
        if (a == 'h28) m_stat = m_stat & ~d;
        if (a == 'h2c) m_mask = d & 'h7f;
    endfunction
    task automatic apb(input logic w, input int a, input int d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= 8'(a);
        pwdata <= 32'(d);
        @(posedge pclk);
        penable <= 1'b1;
        // no local limit: only the bench timeout ends a hung wait
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        chk("pslverr", a > 'h2c, er);
    endtask
    task automatic wr(input int a, input int d);
        apb(1'b1, a, d);
        m_write(a, d);
    endtask
    task automatic rdc(input int a);
        apb(1'b0, a, 0);
        chk("prdata", m_read(a), rd);
    endtask
    task automatic ev(input int v);
        evt_req <= 7'(v);
        @(posedge pclk);
        evt_req <= 7'h00;
        repeat (2) @(posedge pclk);
        m_stat |= v & 'h7f;
    endtask
    // sampled mid-cycle so registered outputs have settled
    task automatic chk_ports();
        @(posedge pclk);
        @(negedge pclk);
        chk("mode", m_mode, current_operating_mode);
        chk("irq", (m_stat & m_mask) != 0, irq);
        chk("txen", m_bsel, buffer_tx_enable);
        for (int b = 0; b < 6; b++)
        begin
            chk("len", m_bsel[b] ? ((m_fc[b] & 15) > 8 ? 8 : m_fc[b] & 15) : 0, buffer_len[4*b +: 4]);
            if (m_bsel[b]) chk("rtr", m_fc[b][6], tx_remote_request[b]);
            if (m_bsel[b]) chk("dlc", m_fc[b] & 15, buffer_dlc[4*b +: 4]);
        end
        @(posedge pclk);
    endtask
    initial
    begin
        void'($urandom(67251));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int a = 0; a <= 'h30; a += 4) rdc(a);
        chk_ports();
        wr('h08, 'hfc);
        rdc('h08);
        for (int m = 3; m >= 0; m--)
        begin
            wr('h00, (m << 5) | ($urandom & 14));
            chk_ports();
            rdc('h00);
            rdc('h04);
        end
        // request config while a frame holds the bus
        frame_start <= 1'b1;
        @(posedge pclk);
        frame_start <= 1'b0;
        repeat (8) @(posedge pclk);
        wr('h00, 'h80);
        chk_ports();
        n = 0;
        do
        begin
            apb(1'b0, 'h04, 0);
            n++;
        end
        while (rd[7:5] !== 3'h4 && n < 30);
        m_mode = 4;
        chk("idle", 1, bus_idle_pin);
        chk("polls", 1, n > 2);
        rdc('h04);
        wr('h0c, 3);
        rdc('h0c);
        for (int r = 0; r < 3; r++)
        begin
            wr('h0c, 1 + r % 2);
            wr('h08, r < 2 ? 'hff : ($urandom | 'h04));
            rdc('h08);
            for (int b = 0; b < 6; b++) wr('h10 + 4 * b, ($urandom & 'h40) | ((b + 6 * r) % 16));
            for (int b = 0; b < 6; b++) rdc('h10 + 4 * b);
            chk_ports();
        end
        wr('h0c, 0);
        chk_ports();
        wr('h2c, 'h7f);
        for (int i = 0; i < 7; i++)
        begin
            ev((1 << i) | 'h40);
            rdc('h04);
            chk_ports();
            wr('h28, 1 << i);
            rdc('h28);
        end
        wr('h2c, 0);
        ev('h7f);
        rdc('h04);
        chk_ports();
        for (int i = 0; i < 4; i++)
        begin
            wr('h2c, $urandom);
            ev($urandom);
            rdc('h04);
            chk_ports();
            wr('h28, $urandom);
            rdc('h28);
        end
        // abort while two buffers still hold frames
        pend_set <= 3'h5;
        @(posedge pclk);
        pend_set <= 3'h0;
        wr('h00, 'h90);
        @(negedge pclk);
        chk("abort", 1, abort_all_tx);
        n = 0;
        while (abort_all_tx !== 1'b0 && n < 8)
        begin
            @(negedge pclk);
            n++;
        end
        chk("pending", 0, tx_pending);
        @(posedge pclk);
        rdc('h00);
        report_and_stop();
    end
endmodule // tb_can_buffer_mode_control
